// ---- ubcu_pkg.sv ----
// Package for the break condition unit: register map, field layout, reset values.
package ubcu_pkg;

   // ==========================================================
   // Register offsets (byte addresses, one aligned word each)
   localparam logic [4:0] UBCU_OFF_ADDR_HIGH = 5'h00;
   localparam logic [4:0] UBCU_OFF_ADDR_LOW  = 5'h04;
   localparam logic [4:0] UBCU_OFF_MASK_HIGH = 5'h08;
   localparam logic [4:0] UBCU_OFF_MASK_LOW  = 5'h0C;
   localparam logic [4:0] UBCU_OFF_CYCLE     = 5'h10;
   localparam logic [4:0] UBCU_OFF_STATUS    = 5'h14;

   // ==========================================================
   // Reset values
   localparam logic [15:0] UBCU_RST_ADDR  = 16'h0000;
   localparam logic [15:0] UBCU_RST_MASK  = 16'h0000;
   localparam logic [7:0]  UBCU_RST_CYCLE = 8'h00;

   // ==========================================================
   // Cycle-type select field positions
   localparam int UBCU_MASTER_HI = 7;
   localparam int UBCU_MASTER_LO = 6;
   localparam int UBCU_FETCH_HI  = 5;
   localparam int UBCU_FETCH_LO  = 4;
   localparam int UBCU_DIR_HI    = 3;
   localparam int UBCU_DIR_LO    = 2;
   localparam int UBCU_SIZE_HI   = 1;
   localparam int UBCU_SIZE_LO   = 0;

   // ==========================================================
   // Operand size encodings
   localparam logic [1:0] UBCU_SIZE_ANY  = 2'h0;
   localparam logic [1:0] UBCU_SIZE_BYTE = 2'h1;
   localparam logic [1:0] UBCU_SIZE_WORD = 2'h2;
   localparam logic [1:0] UBCU_SIZE_LONG = 2'h3;

   // Priority of the break request and the mask level it needs.
   localparam logic [3:0] UBCU_BREAK_LEVEL = 4'hF;

   // Delay line stages after the matching cycle; the registered request reaches the arbiter one cycle later, three cycles after the match.
   localparam int UBCU_REQ_DELAY = 2;

endpackage

// ---- ubcu_break_unit.sv ----
// Break condition unit: register file on classic Wishbone and break request logic.
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/100ps
module ubcu_break_unit
   import ubcu_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Observed bus cycle
   input  wire logic        obs_valid,
   input  wire logic [31:0] obs_addr,
   input  wire logic        obs_dma,
   input  wire logic        obs_fetch,
   input  wire logic        obs_write,
   input  wire logic [1:0]  obs_size,
   input  wire logic        obs_dual_fetch,
   // Interrupt arbiter
   output logic             break_request,
   output logic [3:0]       break_level,
   input  wire logic        break_accept
);
   import ubcu_pkg::*;

   typedef struct packed {
      logic [15:0] addr_high;
      logic [15:0] addr_low;
      logic [15:0] mask_high;
      logic [15:0] mask_low;
      logic [7:0]  cycle_sel;
      logic        ack;
      logic [31:0] rdata;
      logic [1:0]  delay;
      logic        pending;
      logic        matched;
   } ubcu_state_s;

   ubcu_state_s state_reg;
   ubcu_state_s state_next;

   logic [31:0] brk_addr;
   logic [31:0] brk_mask;
   logic [31:0] addr_hit;
   logic [31:0] addr_second;
   logic        hit_first;
   logic        hit_second;
   logic        master_ok;
   logic        kind_ok;
   logic        dir_ok;
   logic        size_ok;
   logic [1:0]  eff_size;
   logic        cycle_match;
   logic        wb_req;
   logic [31:0] wr_merged;
   logic [31:0] cur_word;

   // ==========================================================
   // Match logic
   assign brk_addr = {state_reg.addr_high, state_reg.addr_low};
   assign brk_mask = {state_reg.mask_high, state_reg.mask_low};
   // The second instruction of a dual fetch sits two bytes further on.
   assign addr_second = obs_addr + 32'h0000_0002;

   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_addr
         assign addr_hit[gi] = brk_mask[gi] | (obs_addr[gi] == brk_addr[gi]);
      end
   endgenerate

   assign hit_first  = &addr_hit;
   // both halves are compared in the one bus cycle, so a later rewrite cannot lose them.
   assign hit_second = obs_fetch & obs_dual_fetch & (&(brk_mask | ~(addr_second ^ brk_addr)));

   // a pair at 00 can never be satisfied.
   assign master_ok = obs_dma ? state_reg.cycle_sel[UBCU_MASTER_HI] : state_reg.cycle_sel[UBCU_MASTER_LO];
   assign kind_ok   = obs_fetch ? state_reg.cycle_sel[UBCU_FETCH_LO] : state_reg.cycle_sel[UBCU_FETCH_HI];
   assign dir_ok    = obs_write ? state_reg.cycle_sel[UBCU_DIR_HI] : state_reg.cycle_sel[UBCU_DIR_LO];

   // fetches are always words; data uses its operand size.
   assign eff_size = obs_fetch ? UBCU_SIZE_WORD : obs_size;

   always_comb begin
      unique case (state_reg.cycle_sel[UBCU_SIZE_HI:UBCU_SIZE_LO])
         UBCU_SIZE_ANY:  size_ok = 1'b1;
         UBCU_SIZE_BYTE: size_ok = (eff_size == UBCU_SIZE_BYTE);
         UBCU_SIZE_WORD: size_ok = (eff_size == UBCU_SIZE_WORD);
         UBCU_SIZE_LONG: size_ok = (eff_size == UBCU_SIZE_LONG);
         default:        size_ok = 1'b0;
      endcase
   end

   // Fetches by DMA and fetch writes never appear on the bus, so they never match.
   // Odd word addresses never appear either, so such conditions stay silent.
   assign cycle_match = obs_valid & master_ok & kind_ok & dir_ok & size_ok
                      & (hit_first | hit_second)
                      & ~(obs_fetch & (obs_write | obs_dma));

   // ==========================================================
   // Wishbone slave
   assign wb_req = wb_cyc_i & wb_stb_i & ~state_reg.ack;

   always_comb begin
      cur_word = 32'h0000_0000;
      case (wb_adr_i)
         UBCU_OFF_ADDR_HIGH: cur_word = {16'h0000, state_reg.addr_high};
         UBCU_OFF_ADDR_LOW:  cur_word = {16'h0000, state_reg.addr_low};
         UBCU_OFF_MASK_HIGH: cur_word = {16'h0000, state_reg.mask_high};
         UBCU_OFF_MASK_LOW:  cur_word = {16'h0000, state_reg.mask_low};
         UBCU_OFF_CYCLE:     cur_word = {24'h000000, state_reg.cycle_sel};
         UBCU_OFF_STATUS:    cur_word = {30'h00000000, state_reg.matched, state_reg.pending};
         default:            cur_word = 32'h0000_0000;
      endcase
      for (int b = 0; b < 4; b++) begin
         wr_merged[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : cur_word[b*8 +: 8];
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      state_next = state_reg;
      state_next.ack = wb_req;
      if (wb_req) begin
         state_next.rdata = cur_word;
      end
      if (wb_req && wb_we_i) begin
         case (wb_adr_i)
            UBCU_OFF_ADDR_HIGH: state_next.addr_high = wr_merged[15:0];
            UBCU_OFF_ADDR_LOW:  state_next.addr_low  = wr_merged[15:0];
            UBCU_OFF_MASK_HIGH: state_next.mask_high = wr_merged[15:0];
            UBCU_OFF_MASK_LOW:  state_next.mask_low  = wr_merged[15:0];
            UBCU_OFF_CYCLE:     state_next.cycle_sel = wr_merged[7:0];
            // Writing a one to bit 1 clears the sticky match flag.
            UBCU_OFF_STATUS:    state_next.matched   = state_reg.matched & ~wr_merged[1];
            default:            state_next.cycle_sel = state_reg.cycle_sel;
         endcase
      end
      // Delay line and pending register give the CPU pipeline three cycles before the request.
      state_next.delay = {state_reg.delay[0], cycle_match};
      if (break_accept && state_reg.pending) begin
         state_next.pending = 1'b0;
      end
      // A new match wins over a same-cycle accept so no event is lost.
      if (state_reg.delay[1]) begin
         state_next.pending = 1'b1;
         state_next.matched = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg <= '0;
         state_reg.addr_high <= UBCU_RST_ADDR;
         state_reg.addr_low  <= UBCU_RST_ADDR;
         state_reg.mask_high <= UBCU_RST_MASK;
         state_reg.mask_low  <= UBCU_RST_MASK;
         state_reg.cycle_sel <= UBCU_RST_CYCLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Outputs
   // The arbiter compares the fixed level with the processor mask, and the CPU places
   // the break before the fetched instruction, after delay slots, interrupt-blocked
   // instructions, address errors and the first half of a dual fetch; data breaks
   // land wherever the pipeline stands.
   assign break_request = state_reg.pending;
   assign break_level   = UBCU_BREAK_LEVEL;
   assign wb_ack_o      = state_reg.ack;
   assign wb_dat_o      = state_reg.rdata;

endmodule

// ---- ubcu_arb_model.sv ----
// Interrupt arbiter model on the far side of the break request.
`timescale 1ns/100ps
module ubcu_arb_model (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // Break link
   input  wire logic       break_request,
   input  wire logic [3:0] break_level,
   output logic            break_accept,
   // Processor mask level
   input  wire logic [3:0] mask_level
);
   // A request not above the mask level is left pending, never dropped, so slow answers come free.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         break_accept <= 1'b0;
      end else begin
         break_accept <= break_request && !break_accept && (break_level > mask_level);
      end
   end
endmodule

// ---- ubcu_break_unit_asserts.sv ----
// Port checker for the break condition unit.
`timescale 1ns/100ps
module ubcu_break_unit_asserts
   import ubcu_pkg::*;
(
   // Watched ports
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        obs_valid,
   input wire logic        obs_dma,
   input wire logic        obs_fetch,
   input wire logic        obs_write,
   input wire logic        break_request,
   input wire logic [3:0]  break_level,
   input wire logic        break_accept
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // ====
   // Break link
   property p_level; break_level == UBCU_BREAK_LEVEL; endproperty
   a_level: assert property (p_level) else $error("break level wrong");
   property p_cause; $rose(break_request) |-> $past(obs_valid, 3); endproperty
   a_cause: assert property (p_cause) else $error("request without observed cycle");
   property p_bad_type;
      $rose(break_request) |-> !($past(obs_fetch, 3) && ($past(obs_write, 3) || $past(obs_dma, 3)));
   endproperty
   a_bad_type: assert property (p_bad_type) else $error("impossible cycle type matched");
   property p_hold; break_request && !break_accept |=> break_request; endproperty
   a_hold: assert property (p_hold) else $error("request dropped unaccepted");
   property p_clear; break_request && break_accept && !$past(obs_valid, 2) |=> !break_request; endproperty
   a_clear: assert property (p_clear) else $error("request kept after accept");
   // ====
   // Register bus
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("no ack one cycle after request");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_upper; wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits not zero");
   c_rise: cover property ($rose(break_request));
   c_accept: cover property (break_request && break_accept);
   c_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind ubcu_break_unit ubcu_break_unit_asserts i_chk (.clk_sys, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o,
   .wb_ack_o, .obs_valid, .obs_dma, .obs_fetch, .obs_write, .break_request, .break_level, .break_accept);

// ---- tb.sv ----
// Self-checking testbench for the break condition unit.
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
   import ubcu_pkg::*;
   logic        clk_sys = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [4:0]  wb_adr_i = 5'h00;
   logic [3:0]  wb_sel_i = 4'hF, break_level, mask_level = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, obs_addr = 32'h0, q;
   logic        obs_valid = 1'b0, obs_dma = 1'b0, obs_fetch = 1'b0, obs_write = 1'b0, obs_dual_fetch = 1'b0;
   logic [1:0]  obs_size = 2'h0;
   logic        break_request, break_accept;
   int          errors = 0, check_count = 0, cycles = 0;
   ubcu_break_unit i_dut (.clk_sys, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .obs_valid, .obs_addr, .obs_dma, .obs_fetch, .obs_write, .obs_size, .obs_dual_fetch,
      .break_request, .break_level, .break_accept);
   ubcu_arb_model i_arb (.clk_sys, .reset, .break_request, .break_level, .break_accept, .mask_level);
   always #50 clk_sys = ~clk_sys;
   // ====
   // Bus and observation tasks
   task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin @(posedge clk_sys); n++; end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) errors++;
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic brk(input logic [31:0] a, m, input logic [7:0] s, input logic [31:0] oa,
                      input logic [3:0] ty, input logic [1:0] sz, input logic e);
      wb(1'b1, UBCU_OFF_ADDR_HIGH, {16'h0, a[31:16]}, q);
      wb(1'b1, UBCU_OFF_ADDR_LOW, {16'h0, a[15:0]}, q);
      wb(1'b1, UBCU_OFF_MASK_HIGH, {16'h0, m[31:16]}, q);
      wb(1'b1, UBCU_OFF_MASK_LOW, {16'h0, m[15:0]}, q);
      wb(1'b1, UBCU_OFF_CYCLE, {24'h0, s}, q);
      @(posedge clk_sys);
      obs_valid <= 1'b1;
      obs_addr <= oa;
      {obs_dma, obs_fetch, obs_write, obs_dual_fetch} <= ty;
      obs_size <= sz;
      @(posedge clk_sys);
      obs_valid <= 1'b0;
      repeat (4) @(posedge clk_sys);
      `CHK(break_request, e)
      `CHK(break_level, UBCU_BREAK_LEVEL)
      repeat (5) @(posedge clk_sys);
      `CHK(break_request, e)
      mask_level <= 4'hE;
      repeat (4) @(posedge clk_sys);
      `CHK(break_request, 1'b0)
      mask_level <= 4'hF;
      wb(1'b0, UBCU_OFF_STATUS, 32'h0, q);
      `CHK(q, {30'h0, e, 1'b0})
      wb(1'b1, UBCU_OFF_STATUS, 32'h2, q);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         test_done;
      end
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      for (int i = 0; i < 7; i++) begin wb(1'b0, 5'(i * 4), 32'h0, q); `CHK(q, 32'h0) end
      wb(1'b1, UBCU_OFF_MASK_HIGH, 32'hFFFFABCD, q);
      wb(1'b0, UBCU_OFF_MASK_HIGH, 32'h0, q);
      `CHK(q, 32'h0000ABCD)
      wb(1'b1, UBCU_OFF_CYCLE, 32'h00001234, q);
      wb(1'b0, UBCU_OFF_CYCLE, 32'h0, q);
      `CHK(q, 32'h00000034)
      wb(1'b1, 5'h18, 32'hFFFFFFFF, q);
      wb(1'b0, 5'h18, 32'h0, q);
      `CHK(q, 32'h0)
      $display("register test done");
      brk(32'h00000404, 32'h0, 8'h54, 32'h00000404, 4'b0100, 2'h2, 1'b1);
      brk(32'h0015389C, 32'h0, 8'h58, 32'h0015389C, 4'b0110, 2'h2, 1'b0);
      brk(32'h00123456, 32'h0, 8'h6A, 32'h00123456, 4'b0010, 2'h2, 1'b1);
      brk(32'h0076BCDC, 32'h0, 8'hA7, 32'h0076BCDC, 4'b1000, 2'h3, 1'b1);
      brk(32'h0076BCDC, 32'h0, 8'hA7, 32'h0076BCDC, 4'b1000, 2'h2, 1'b0);
      brk(32'h002345C8, 32'h0, 8'h94, 32'h002345C8, 4'b1100, 2'h2, 1'b0);
      brk(32'h00000404, 32'h0, 8'h14, 32'h00000404, 4'b0100, 2'h2, 1'b0);
      brk(32'h00000404, 32'h0, 8'h44, 32'h00000404, 4'b0000, 2'h2, 1'b0);
      brk(32'h00000404, 32'h0, 8'h50, 32'h00000404, 4'b0100, 2'h2, 1'b0);
      brk(32'h00001000, 32'hFF, 8'h69, 32'h000010AB, 4'b0010, 2'h1, 1'b1);
      brk(32'h00001000, 32'hFE, 8'h69, 32'h000010AB, 4'b0010, 2'h1, 1'b0);
      brk(32'h00001000, 32'hFF, 8'h69, 32'h000010AB, 4'b0010, 2'h2, 1'b0);
      brk(32'h00000406, 32'h0, 8'h56, 32'h00000404, 4'b0101, 2'h3, 1'b1);
      brk(32'h00A80391, 32'h0, 8'h66, 32'h00A80390, 4'b0000, 2'h2, 1'b0);
      $display("break test done");
      test_done;
   end
endmodule
